/* rtl/upd_pkg.sv */
// Purpose: constants for the uart pin, dma and reset logic
// Assumes: register selects as on the three address pins
// Notes:   offsets are the address pin codes
package upd_pkg;
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_IEN    = 3'h1;
    localparam logic [2:0] ADDR_IID    = 3'h2;
    localparam logic [2:0] ADDR_LCTL   = 3'h3;
    localparam logic [2:0] ADDR_MCTL   = 3'h4;
    localparam logic [2:0] ADDR_LSTAT  = 3'h5;
    localparam logic [2:0] ADDR_MSTAT  = 3'h6;
    localparam logic [2:0] ADDR_SCR    = 3'h7;
    localparam logic [7:0] RST_IEN     = 8'h00;
    localparam logic [7:0] RST_IID     = 8'h01;
    localparam logic [7:0] RST_FCTL    = 8'h00;
    localparam logic [7:0] RST_LCTL    = 8'h00;
    localparam logic [7:0] RST_MCTL    = 8'h00;
    localparam logic [7:0] RST_LSTAT   = 8'h60;
    localparam logic [7:0] IEN_MASK    = 8'h0f;
    localparam logic [7:0] MCTL_MASK   = 8'h1f;
    localparam int         FC_ENABLE   = 0;
    localparam int         FC_RXRST    = 1;
    localparam int         FC_TXRST    = 2;
    localparam int         FC_DMA      = 3;
    localparam int         MC_RTS      = 1;
    localparam int         MC_LOOP     = 4;
    localparam int         IE_MODEM    = 3;
    localparam int         LC_DLAB     = 7;
    localparam int         LS_DR       = 0;
    localparam int         LS_THRE     = 5;
    localparam int         LS_TEMT     = 6;
    localparam int         MS_RING_TRAILING_EDGE_FLAG     = 2;
    localparam int         RX_OVERSAMPLE = 16;
endpackage : upd_pkg

/* rtl/upd_uart_pins.sv */
// Purpose: host strobes, ring status, rts, serial out, dma request pins, reset state
// Assumes: rst_n is the synchronous master reset, strobes, chip select, 16x clock and modem pins synchronised here
// Notes:   framing and baud arithmetic live elsewhere; fifo levels arrive as inputs
//
// Summary of operation
// - receiver runs from separate 16x baud input
// - either read strobe polarity reads selected register
// - either write strobe polarity writes selected register
// - status bit 6 is inverted ring input
// - status bit 2 flags ring trailing edge
// - ring trailing edge raises enabled interrupt
// - rts low when control bit 1 set
// - rts high on reset and in loopback
// - serial output idles high at reset
// - fifo control bit 3 picks dma mode
// - mode 0 receive request while data held
// - mode 1 receive request on trigger/timeout
// - mode 0 transmit request while holding empty
// - mode 1 transmit request empty until full
// - reset clears status low bits, high live
// - permanently low bits always read zero
// - reset clears registers except data and divisor
`timescale 1ns/10ps
module upd_uart_pins #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       chipSelect,
    input  wire logic [2:0] regAddr,
    input  wire logic       readHigh,
    input  wire logic       readLow_n,
    input  wire logic       writeHigh,
    input  wire logic       writeLow_n,
    input  wire logic [7:0] hostDataIn,
    output logic      [7:0] hostDataOut,
    output logic            hostDataOe,
    input  wire logic       rxBaudClk16,
    output logic            rxSampleTick,
    input  wire logic       ringIn_n,
    input  wire logic       ctsIn_n,
    input  wire logic       dsrIn_n,
    input  wire logic       dcdIn_n,
    output logic            rtsOut_n,
    input  wire logic       txSerial,
    output logic            serial_out_pin,
    input  wire logic [4:0] rxCount,
    input  wire logic       rxTriggerHit,
    input  wire logic       rxTimeout,
    input  wire logic [4:0] txCount,
    output logic            rxFifoClear,
    output logic            txFifoClear,
    output logic            txWrite,
    output logic            rxRead,
    output logic            receive_dma_request,
    output logic            transmit_dma_request,
    output logic            interruptOut
);
    import upd_pkg::*;

    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch;
    logic [3:0] modemDelta;
    logic [3:0] pinSync1;
    logic [3:0] pinSync2;
    logic [3:0] pinPrev;
    logic [3:0] strobeSync1;
    logic [3:0] strobeSync2;
    logic       readPrev;
    logic       writePrev;
    logic [2:0] clkSync;
    logic       csSync1;
    logic       csSync2;
    logic       rxDmaActive;
    logic       txDmaActive;
    logic       readActive;
    logic       writeActive;
    logic       readPulse;
    logic       writePulse;
    logic       fifoMode;
    logic       dmaMode1;
    logic       loopMode;
    logic [3:0] modemLive;
    logic [7:0] modemStatus;
    logic [7:0] lineStatus;
    logic [7:0] intIdent;
    logic [7:0] next_readData;
    logic       readMstat;

    // pins are asynchronous to clk, two stages before any use
    // address and data settle before the synced strobe, so they stay unsynced
    always_ff @(posedge clk)
    begin
        pinSync1    <= {dcdIn_n, ringIn_n, dsrIn_n, ctsIn_n};
        pinSync2    <= pinSync1;
        strobeSync1 <= {readHigh, ~readLow_n, writeHigh, ~writeLow_n};
        strobeSync2 <= strobeSync1;
        clkSync     <= {clkSync[1:0], rxBaudClk16};
        csSync1     <= chipSelect;
        csSync2     <= csSync1;
    end

    // unused strobe is tied inactive by the board, so an or is safe
    assign readActive  = csSync2 & (strobeSync2[3] | strobeSync2[2]);
    assign writeActive = csSync2 & (strobeSync2[1] | strobeSync2[0]);
    assign readPulse   = readActive & ~readPrev;
    assign writePulse  = writeActive & ~writePrev;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            readPrev  <= 1'b0;
            writePrev <= 1'b0;
        end
        else
        begin
            readPrev  <= readActive;
            writePrev <= writeActive;
        end
    end

    // one tick per rising edge of the receiver's own 16x clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rxSampleTick <= 1'b0;
        else
            rxSampleTick <= clkSync[1] & ~clkSync[2];
    end

    assign fifoMode  = fifo_control[FC_ENABLE];
    assign dmaMode1  = fifoMode & fifo_control[FC_DMA];
    assign loopMode  = modem_control[MC_LOOP];
    assign modemLive = ~pinSync2;

    // write path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            interrupt_enable <= RST_IEN;
            fifo_control     <= RST_FCTL;
            line_control     <= RST_LCTL;
            modem_control    <= RST_MCTL;
            scratch          <= 8'h00;
        end
        else if (writePulse)
        begin
            unique case (regAddr)
                ADDR_IEN:
                begin
                    if (!line_control[LC_DLAB])
                        interrupt_enable <= hostDataIn & IEN_MASK;
                end
                ADDR_IID:  fifo_control  <= {hostDataIn[7:6], 2'b00, hostDataIn[FC_DMA], 3'b000};
                ADDR_LCTL: line_control  <= hostDataIn;
                ADDR_MCTL: modem_control <= hostDataIn & MCTL_MASK;
                ADDR_SCR:  scratch       <= hostDataIn;
                default:   ;
            endcase
            if (regAddr == ADDR_IID)
                fifo_control[FC_ENABLE] <= hostDataIn[FC_ENABLE];
        end
    end

    // fifo clears: reset, reset bits with enable, or enable toggled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rxFifoClear <= 1'b1;
            txFifoClear <= 1'b1;
        end
        else
        begin
            rxFifoClear <= writePulse && regAddr == ADDR_IID &&
                           ((hostDataIn[FC_RXRST] & hostDataIn[FC_ENABLE]) ||
                            (hostDataIn[FC_ENABLE] != fifoMode));
            txFifoClear <= writePulse && regAddr == ADDR_IID &&
                           ((hostDataIn[FC_TXRST] & hostDataIn[FC_ENABLE]) ||
                            (hostDataIn[FC_ENABLE] != fifoMode));
        end
    end

    assign readMstat = readPulse && regAddr == ADDR_MSTAT;

    // delta flags: set wins over the read that clears them
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            modemDelta <= 4'h0;
            pinPrev    <= 4'hf;
        end
        else
        begin
            pinPrev <= pinSync2;
            modemDelta[0] <= (pinSync2[0] != pinPrev[0]) | (modemDelta[0] & ~readMstat);
            modemDelta[1] <= (pinSync2[1] != pinPrev[1]) | (modemDelta[1] & ~readMstat);
            modemDelta[MS_RING_TRAILING_EDGE_FLAG] <= (pinSync2[2] & ~pinPrev[2]) | (modemDelta[MS_RING_TRAILING_EDGE_FLAG] & ~readMstat);
            modemDelta[3] <= (pinSync2[3] != pinPrev[3]) | (modemDelta[3] & ~readMstat);
        end
    end

    assign modemStatus = {modemLive[3:0], modemDelta};

    assign lineStatus = {1'b0, (txCount == 5'd0), (txCount == 5'd0), 4'h0, (rxCount != 5'd0)};

    // interrupt id: only the modem-status source is handled here
    assign intIdent = {fifoMode, fifoMode, 2'b00, 3'b000,
                       ~(interrupt_enable[IE_MODEM] & (|modemDelta))};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            interruptOut <= 1'b0;
        else
            interruptOut <= interrupt_enable[IE_MODEM] & (|modemDelta);
    end

    always_comb
    begin
        next_readData = 8'h00;
        unique case (regAddr)
            ADDR_IEN:   next_readData = interrupt_enable & IEN_MASK;
            ADDR_IID:   next_readData = intIdent;
            ADDR_LCTL:  next_readData = line_control;
            ADDR_MCTL:  next_readData = modem_control & MCTL_MASK;
            ADDR_LSTAT: next_readData = lineStatus;
            ADDR_MSTAT: next_readData = modemStatus;
            ADDR_SCR:   next_readData = scratch;
            default:    next_readData = 8'h00;
        endcase
    end

    // data register read and write are handed to the fifo logic as pulses
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hostDataOut <= 8'h00;
            txWrite     <= 1'b0;
            rxRead      <= 1'b0;
        end
        else
        begin
            if (readActive)
                hostDataOut <= next_readData;
            txWrite <= writePulse && regAddr == ADDR_DATA && !line_control[LC_DLAB];
            rxRead  <= readPulse && regAddr == ADDR_DATA && !line_control[LC_DLAB];
        end
    end

    assign hostDataOe = readActive & readPrev;

    // loopback holds the modem output inactive
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rtsOut_n       <= 1'b1;
            serial_out_pin <= 1'b1;
        end
        else
        begin
            rtsOut_n       <= ~(modem_control[MC_RTS] & ~loopMode);
            serial_out_pin <= loopMode ? 1'b1 : txSerial;
        end
    end

    // dma requests are active low; mode 1 latches until empty or full
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rxDmaActive <= 1'b0;
            txDmaActive <= 1'b1;
        end
        else
        begin
            if (!dmaMode1)
                rxDmaActive <= rxCount != 5'd0;
            else if (rxCount == 5'd0)
                rxDmaActive <= 1'b0;
            else if (rxTriggerHit | rxTimeout)
                rxDmaActive <= 1'b1;
            if (!dmaMode1)
                txDmaActive <= txCount == 5'd0;
            else if (txCount == 5'(FIFO_DEPTH))
                txDmaActive <= 1'b0;
            else if (txCount == 5'd0)
                txDmaActive <= 1'b1;
        end
    end

    assign receive_dma_request  = ~rxDmaActive;
    assign transmit_dma_request = ~txDmaActive;

endmodule : upd_uart_pins

/* testbench/upd_uart_pins_sva.sv */
// Purpose: port level checks for upd_uart_pins
// Assumes: rst_n synchronous active low
// Notes:   register contents are judged by the bench
`timescale 1ns/10ps
module upd_uart_pins_sva #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       readHigh,
    input wire logic       readLow_n,
    input wire logic       hostDataOe,
    input wire logic       rxBaudClk16,
    input wire logic       rxSampleTick,
    input wire logic       rtsOut_n,
    input wire logic       serial_out_pin,
    input wire logic [4:0] rxCount,
    input wire logic [4:0] txCount,
    input wire logic       rxFifoClear,
    input wire logic       txFifoClear,
    input wire logic       receive_dma_request,
    input wire logic       transmit_dma_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rdAct;
    assign rdAct = readHigh | ~readLow_n;
    rts_reset_a: assert property ($rose(rst_n) |-> rtsOut_n) else $error("rts active after reset");
    serial_out_pin_reset_a: assert property ($rose(rst_n) |-> serial_out_pin) else $error("serial out low after reset");
    fifo_clear_a: assert property ($rose(rst_n) |-> rxFifoClear && txFifoClear) else $error("no fifo clear");
    rx_empty_a: assert property ((rxCount == 5'h00) [*3] |-> receive_dma_request) else $error("rx request");
    tx_empty_a: assert property ((txCount == 5'h00) [*3] |-> !transmit_dma_request) else $error("tx idle");
    tx_full_a: assert property ((txCount == 5'(FIFO_DEPTH)) [*3] |-> transmit_dma_request) else $error("tx full");
    // bus drive must trail the synced strobe, never lead it
    read_drive_a: assert property (hostDataOe |-> $past(rdAct, 2) || $past(rdAct, 3)) else $error("stray drive");
    tick_pulse_a: assert property (rxSampleTick |=> !rxSampleTick) else $error("tick too long");
    rx_tick_a: assert property ($rose(rxBaudClk16) |-> ##[1:5] rxSampleTick) else $error("tick missing");
    cover property ($fell(receive_dma_request));
    cover property ($rose(transmit_dma_request));
    cover property (hostDataOe);
endmodule : upd_uart_pins_sva
bind upd_uart_pins upd_uart_pins_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .rst_n, .readHigh, .readLow_n, .hostDataOe,
    .rxBaudClk16, .rxSampleTick, .rtsOut_n, .serial_out_pin, .rxCount, .txCount, .rxFifoClear, .txFifoClear,
    .receive_dma_request, .transmit_dma_request);

/* testbench/upd_host_model.sv */
// Purpose: host processor bus model
// Assumes: strobes need two synced cycles low between accesses
// Notes:   one strobe polarity per access, the other held idle
`timescale 1ns/10ps
module upd_host_model (
    input  wire logic       clk,
    output logic            chipSelect,
    output logic      [2:0] regAddr,
    output logic            readHigh,
    output logic            readLow_n,
    output logic            writeHigh,
    output logic            writeLow_n,
    output logic      [7:0] hostDataIn,
    input  wire logic [7:0] hostDataOut
);
    initial
    begin
        {chipSelect, regAddr, readHigh, readLow_n, writeHigh, writeLow_n, hostDataIn} = 16'h0500;
    end
    task automatic access(input logic rd, input logic hi, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk);
        chipSelect <= 1'b1;
        regAddr    <= a;
        hostDataIn <= d;
        readHigh   <= rd & hi;
        readLow_n  <= ~(rd & ~hi);
        writeHigh  <= ~rd & hi;
        writeLow_n <= ~(~rd & ~hi);
        repeat (3) @(posedge clk);
        // first valid cycle only: a status read clears its flags and the bus follows
        @(negedge clk);
        q = hostDataOut;
        @(posedge clk);
        {readHigh, readLow_n, writeHigh, writeLow_n} <= 4'h5;
        repeat (3) @(posedge clk);
        chipSelect <= 1'b0;
        hostDataIn <= ~d;
        repeat (2) @(posedge clk);
    endtask : access
endmodule : upd_host_model

/* testbench/upd_uart_pins_tb.sv */
// Purpose: self-checking bench for upd_uart_pins
// Assumes: host model owns the register strobes
// Notes:   modem and fifo level inputs are driven here
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errorCnt++; $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module upd_uart_pins_tb;
    import upd_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, rxBaudClk16 = 1'b0, ringIn_n = 1'b1, txSerial = 1'b0;
    logic       ctsIn_n = 1'b1, dsrIn_n = 1'b1, dcdIn_n = 1'b1;
    logic       rxTriggerHit = 1'b0, rxTimeout = 1'b0;
    logic [4:0] rxCount = 5'h00, txCount = 5'h00;
    logic       chipSelect, readHigh, readLow_n, writeHigh, writeLow_n;
    logic [2:0] regAddr;
    logic [7:0] hostDataIn, hostDataOut;
    logic       hostDataOe, rxSampleTick, rtsOut_n, serial_out_pin, rxFifoClear, txFifoClear;
    logic       txWrite, rxRead, receive_dma_request, transmit_dma_request, interruptOut;
    int         errorCnt = 0, comparisons = 0, tickCnt = 0;
    int         wrCnt = 0, rdCnt = 0, rxClrCnt = 0, txClrCnt = 0;
    upd_uart_pins #(.FIFO_DEPTH(16)) dut (.clk, .rst_n, .chipSelect, .regAddr, .readHigh, .readLow_n, .writeHigh,
        .writeLow_n, .hostDataIn, .hostDataOut, .hostDataOe, .rxBaudClk16, .rxSampleTick, .ringIn_n, .ctsIn_n,
        .dsrIn_n, .dcdIn_n, .rtsOut_n, .txSerial, .serial_out_pin, .rxCount, .rxTriggerHit, .rxTimeout,
        .txCount, .rxFifoClear, .txFifoClear, .txWrite, .rxRead, .receive_dma_request, .transmit_dma_request,
        .interruptOut);
    upd_host_model host (.clk, .chipSelect, .regAddr, .readHigh, .readLow_n, .writeHigh, .writeLow_n, .hostDataIn,
        .hostDataOut);
    always #2 clk = ~clk;
    always @(posedge clk) if (rxSampleTick === 1'b1) tickCnt <= tickCnt + 1;
    // pulse counters; clear and write counts are compared as differences, so reset-held clears do not matter
    always @(posedge clk)
    begin
        if (txWrite === 1'b1) wrCnt <= wrCnt + 1;
        if (rxRead === 1'b1) rdCnt <= rdCnt + 1;
        if (rxFifoClear === 1'b1) rxClrCnt <= rxClrCnt + 1;
        if (txFifoClear === 1'b1) txClrCnt <= txClrCnt + 1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b0, a[0], a, d, q);
    endtask : wr
    task automatic rdChk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.access(1'b1, a[1], a, 8'h00, q);
        `CHK(q, e)
    endtask : rdChk
    task automatic drive(input logic [4:0] rc, input logic [4:0] tc, input logic trig, input logic tmo);
        @(posedge clk);
        {rxCount, txCount, rxTriggerHit, rxTimeout} <= {rc, tc, trig, tmo};
        cyc(4);
    endtask : drive
    task automatic testReset();
        rdChk(ADDR_IEN, RST_IEN);
        rdChk(ADDR_IID, RST_IID);
        rdChk(ADDR_LCTL, RST_LCTL);
        rdChk(ADDR_MCTL, RST_MCTL);
        rdChk(ADDR_LSTAT, RST_LSTAT);
        rdChk(ADDR_MSTAT, 8'h00);
        wr(ADDR_IEN, 8'hff);
        rdChk(ADDR_IEN, 8'h0f);
    endtask : testReset
    task automatic testRing();
        @(posedge clk) ringIn_n <= 1'b0;
        cyc(6);
        `CHK(interruptOut, 1'b0)
        rdChk(ADDR_MSTAT, 8'h40);
        @(posedge clk) ringIn_n <= 1'b1;
        cyc(6);
        `CHK(interruptOut, 1'b1)
        rdChk(ADDR_MSTAT, 8'h04);
        `CHK(interruptOut, 1'b0)
        rdChk(ADDR_MSTAT, 8'h00);
        @(posedge clk) {dcdIn_n, dsrIn_n, ctsIn_n} <= 3'h0;
        cyc(6);
        rdChk(ADDR_MSTAT, 8'hbb);
        @(posedge clk) {dcdIn_n, dsrIn_n, ctsIn_n} <= 3'h7;
        cyc(6);
        rdChk(ADDR_MSTAT, 8'h0b);
    endtask : testRing
    task automatic testRts();
        int w0;
        wr(ADDR_MCTL, 8'h02);
        `CHK(rtsOut_n, 1'b0)
        wr(ADDR_MCTL, 8'h12);
        `CHK(rtsOut_n, 1'b1)
        rdChk(ADDR_MCTL, 8'h12);
        wr(ADDR_MCTL, 8'h00);
        `CHK(rtsOut_n, 1'b1)
        w0 = wrCnt;
        wr(ADDR_DATA, 8'h55);
        `CHK(wrCnt - w0, 1)
        wr(ADDR_LCTL, 8'h80);
        wr(ADDR_DATA, 8'h66);
        wr(ADDR_IEN, 8'h00);
        wr(ADDR_LCTL, 8'h00);
        `CHK(wrCnt - w0, 1)
        rdChk(ADDR_IEN, 8'h0f);
        rdChk(ADDR_DATA, 8'h00);
        `CHK(rdCnt, 1)
    endtask : testRts
    task automatic testDma();
        int c0;
        int c1;
        drive(5'h01, 5'h00, 1'b0, 1'b0);
        `CHK(receive_dma_request, 1'b0)
        drive(5'h00, 5'h01, 1'b0, 1'b0);
        `CHK(receive_dma_request, 1'b1)
        `CHK(transmit_dma_request, 1'b1)
        c0 = rxClrCnt;
        c1 = txClrCnt;
        wr(ADDR_IID, 8'h09);
        `CHK(rxClrCnt - c0, 1)
        `CHK(txClrCnt - c1, 1)
        drive(5'h01, 5'h00, 1'b0, 1'b0);
        `CHK(receive_dma_request, 1'b1)
        drive(5'h01, 5'h01, 1'b0, 1'b1);
        `CHK(receive_dma_request, 1'b0)
        `CHK(transmit_dma_request, 1'b0)
        drive(5'h00, 5'h10, 1'b0, 1'b0);
        `CHK(receive_dma_request, 1'b1)
        `CHK(transmit_dma_request, 1'b1)
        drive(5'h02, 5'h00, 1'b1, 1'b0);
        `CHK(receive_dma_request, 1'b0)
        wr(ADDR_IID, 8'h0b);
        `CHK(rxClrCnt - c0, 2)
        `CHK(txClrCnt - c1, 1)
        wr(ADDR_IID, 8'h08);
        `CHK(rxClrCnt - c0, 3)
        `CHK(txClrCnt - c1, 2)
        drive(5'h00, 5'h00, 1'b0, 1'b0);
        `CHK(receive_dma_request, 1'b1)
        drive(5'h01, 5'h00, 1'b0, 1'b0);
        `CHK(receive_dma_request, 1'b0)
    endtask : testDma
    task automatic testMidReset();
        wr(ADDR_MCTL, 8'h02);
        `CHK(rtsOut_n, 1'b0)
        `CHK(serial_out_pin, 1'b0)
        @(posedge clk) rst_n <= 1'b0;
        cyc(3);
        `CHK(rtsOut_n, 1'b1)
        `CHK(serial_out_pin, 1'b1)
        `CHK(rxFifoClear & txFifoClear, 1'b1)
        `CHK(interruptOut, 1'b0)
        rst_n <= 1'b1;
        rdChk(ADDR_IEN, RST_IEN);
        rdChk(ADDR_MCTL, RST_MCTL);
        rdChk(ADDR_IID, RST_IID);
    endtask : testMidReset
    task automatic testTick();
        tickCnt = 0;
        repeat (4)
        begin
            @(posedge clk) rxBaudClk16 <= 1'b1;
            cyc(8);
            @(posedge clk) rxBaudClk16 <= 1'b0;
            cyc(8);
        end
        `CHK(tickCnt, 4)
    endtask : testTick
    task automatic stopTest();
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stopTest
    initial
    begin
        cyc(3);
        rst_n <= 1'b1;
        testReset();
        testRing();
        testRts();
        testDma();
        testMidReset();
        testTick();
        stopTest();
    end
    // well above the few hundred cycles the tests need
    initial
    begin
        cyc(20000);
        errorCnt++;
        stopTest();
    end
endmodule : upd_uart_pins_tb
